//--- src/gpio_def_pkg.sv
// Constants and register map for the port D, E and F pin logic
package gpio_def_pkg;

  // ***********************************************************
  // Bus geometry
  // ***********************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int IDX_W  = 14;

  // ***********************************************************
  // Register indices (byte address is four times the index)
  // ***********************************************************
  localparam logic [IDX_W-1:0] IDX_PORT_D_DATA = 14'h0003;
  localparam logic [IDX_W-1:0] IDX_PORT_E_DATA = 14'h0008;
  localparam logic [IDX_W-1:0] IDX_PORT_F_DATA = 14'h0440;
  localparam logic [IDX_W-1:0] IDX_PORT_D_DIR  = 14'h0010;
  localparam logic [IDX_W-1:0] IDX_PORT_D_PUE  = 14'h0011;
  localparam logic [IDX_W-1:0] IDX_PORT_E_DIR  = 14'h0012;
  localparam logic [IDX_W-1:0] IDX_PORT_F_DIR  = 14'h0013;

  // ***********************************************************
  // Port widths and pin packing
  // ***********************************************************
  localparam int PD_W   = 8;
  localparam int PE_W   = 6;
  localparam int PF_W   = 8;
  localparam int PIN_W  = PD_W + PE_W + PF_W;
  localparam int PD_LSB = 0;
  localparam int PE_LSB = PD_W;
  localparam int PF_LSB = PD_W + PE_W;

  // Shared pin positions
  localparam int PE_TX_BIT = 0;
  localparam int PE_RX_BIT = 1;
  localparam int SPI_W     = 4;
  localparam int TIM_LSB   = 4;
  localparam int TIM_W     = 4;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [PD_W-1:0] PD_DIR_RST = 8'h00;
  localparam logic [PD_W-1:0] PD_PUE_RST = 8'h00;
  localparam logic [PE_W-1:0] PE_DIR_RST = 6'h00;
  localparam logic [PF_W-1:0] PF_DIR_RST = 8'h00;

  // ***********************************************************
  // AXI responses
  // ***********************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpio_def_pkg

//--- src/gpio_ports_d_e_f.sv
// Port D, E and F general-purpose pin logic with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module gpio_ports_d_e_f (
  // Clock and reset
  input  wire  logic                               i_mclk,
  input  wire  logic                               i_reset,
  // AXI4-Lite write address
  input  wire  logic                               i_axi_awvalid,
  output logic                                     o_axi_awready,
  input  wire  logic [gpio_def_pkg::ADDR_W-1:0]    i_axi_awaddr,
  input  wire  logic [2:0]                         i_axi_awprot,
  // AXI4-Lite write data
  input  wire  logic                               i_axi_wvalid,
  output logic                                     o_axi_wready,
  input  wire  logic [gpio_def_pkg::DATA_W-1:0]    i_axi_wdata,
  input  wire  logic [gpio_def_pkg::DATA_W/8-1:0]  i_axi_wstrb,
  // AXI4-Lite write response
  output logic                                     o_axi_bvalid,
  input  wire  logic                               i_axi_bready,
  output logic [1:0]                               o_axi_bresp,
  // AXI4-Lite read address
  input  wire  logic                               i_axi_arvalid,
  output logic                                     o_axi_arready,
  input  wire  logic [gpio_def_pkg::ADDR_W-1:0]    i_axi_araddr,
  input  wire  logic [2:0]                         i_axi_arprot,
  // AXI4-Lite read data
  output logic                                     o_axi_rvalid,
  input  wire  logic                               i_axi_rready,
  output logic [gpio_def_pkg::DATA_W-1:0]          o_axi_rdata,
  output logic [1:0]                               o_axi_rresp,
  // Port D pads
  input  wire  logic [gpio_def_pkg::PD_W-1:0]      i_pd_in,
  output logic [gpio_def_pkg::PD_W-1:0]            o_pd_out,
  output logic [gpio_def_pkg::PD_W-1:0]            o_pd_oe_n,
  output logic [gpio_def_pkg::PD_W-1:0]            o_pd_pullup,
  // Port E pads
  input  wire  logic [gpio_def_pkg::PE_W-1:0]      i_pe_in,
  output logic [gpio_def_pkg::PE_W-1:0]            o_pe_out,
  output logic [gpio_def_pkg::PE_W-1:0]            o_pe_oe_n,
  // Port F pads
  input  wire  logic [gpio_def_pkg::PF_W-1:0]      i_pf_in,
  output logic [gpio_def_pkg::PF_W-1:0]            o_pf_out,
  output logic [gpio_def_pkg::PF_W-1:0]            o_pf_oe_n,
  // SPI peripheral on port D bits 3 to 0
  input  wire  logic [gpio_def_pkg::SPI_W-1:0]     i_spi_claim,
  input  wire  logic [gpio_def_pkg::SPI_W-1:0]     i_spi_drive,
  input  wire  logic [gpio_def_pkg::SPI_W-1:0]     i_spi_out,
  output logic [gpio_def_pkg::SPI_W-1:0]           o_spi_in,
  // Serial interface on port E bits 1 and 0
  input  wire  logic                               i_serial_if_enable,
  input  wire  logic                               i_serial_txd,
  output logic                                     o_serial_rxd,
  // Second timer channels on port F bits 7 to 4
  input  wire  logic [gpio_def_pkg::TIM_W-1:0]     i_timer_claim,
  input  wire  logic [gpio_def_pkg::TIM_W-1:0]     i_timer_drive,
  input  wire  logic [gpio_def_pkg::TIM_W-1:0]     i_timer_out,
  output logic [gpio_def_pkg::TIM_W-1:0]           o_timer_in
);
  import gpio_def_pkg::*;

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic [PD_W-1:0]   pd_latch;
    logic [PD_W-1:0]   pd_dir;
    logic [PD_W-1:0]   pd_pue;
    logic [PE_W-1:0]   pe_latch;
    logic [PE_W-1:0]   pe_dir;
    logic [PF_W-1:0]   pf_latch;
    logic [PF_W-1:0]   pf_dir;
    logic [PIN_W-1:0]  sync1;
    logic [PIN_W-1:0]  sync2;
    logic [PIN_W-1:0]  sync3;
    logic [PIN_W-1:0]  pin_lvl;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [REG_W-1:0]  w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [REG_W-1:0]  rdata;
    logic [1:0]        rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0]  idx);
    reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

  // Latch where driven, pin level where input
  function automatic logic [REG_W-1:0] port_read(
      input logic [REG_W-1:0] dir,
      input logic [REG_W-1:0] latch,
      input logic [REG_W-1:0] pin);
    port_read = (dir & latch) | (~dir & pin);
  endfunction : port_read

  logic [PD_W-1:0] pd_lvl;
  logic [PE_W-1:0] pe_lvl;
  logic [PF_W-1:0] pf_lvl;

  assign pd_lvl = st_r.pin_lvl[PD_LSB +: PD_W];
  assign pe_lvl = st_r.pin_lvl[PE_LSB +: PE_W];
  assign pf_lvl = st_r.pin_lvl[PF_LSB +: PF_W];

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    logic            w_ok;
    logic            r_ok;
    logic [REG_W-1:0] r_val;
    w_ok   = 1'b1;
    r_ok   = 1'b1;
    r_val  = '0;
    st_nxt = st_r;

    // Three-stage pin sampling; accept when stages two and three agree
    st_nxt.sync1   = {i_pf_in, i_pe_in, i_pd_in};
    st_nxt.sync2   = st_r.sync1;
    st_nxt.sync3   = st_r.sync2;
    st_nxt.pin_lvl = (st_r.sync2 & st_r.sync3)
                   | (st_r.pin_lvl & (st_r.sync2 ^ st_r.sync3));

    // Response handshakes
    if (st_r.bvalid && i_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && i_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Address and data taken in either order
    if (i_axi_awvalid && o_axi_awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      st_nxt.w_have  = 1'b1;
      st_nxt.w_data  = i_axi_wdata[REG_W-1:0];
      st_nxt.w_lane0 = i_axi_wstrb[0];
    end

    // Register write once both halves are held
    if (st_r.aw_have && st_r.w_have) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      if (reg_hit(st_r.aw_addr, IDX_PORT_D_DATA)) begin
        if (st_r.w_lane0) begin
          st_nxt.pd_latch = st_r.w_data;
        end
      end else if (reg_hit(st_r.aw_addr, IDX_PORT_E_DATA)) begin
        if (st_r.w_lane0) begin
          st_nxt.pe_latch = st_r.w_data[PE_W-1:0];
        end
      end else if (reg_hit(st_r.aw_addr, IDX_PORT_F_DATA)) begin
        if (st_r.w_lane0) begin
          st_nxt.pf_latch = st_r.w_data;
        end
      end else if (reg_hit(st_r.aw_addr, IDX_PORT_D_DIR)) begin
        if (st_r.w_lane0) begin
          st_nxt.pd_dir = st_r.w_data;
        end
      end else if (reg_hit(st_r.aw_addr, IDX_PORT_D_PUE)) begin
        if (st_r.w_lane0) begin
          st_nxt.pd_pue = st_r.w_data;
        end
      end else if (reg_hit(st_r.aw_addr, IDX_PORT_E_DIR)) begin
        if (st_r.w_lane0) begin
          st_nxt.pe_dir = st_r.w_data[PE_W-1:0];
        end
      end else if (reg_hit(st_r.aw_addr, IDX_PORT_F_DIR)) begin
        if (st_r.w_lane0) begin
          st_nxt.pf_dir = st_r.w_data;
        end
      end else begin
        w_ok = 1'b0;
      end
      st_nxt.bresp = w_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Register read; input pins show the sampled level
    if (i_axi_arvalid && o_axi_arready) begin
      if (reg_hit(i_axi_araddr, IDX_PORT_D_DATA)) begin
        r_val = port_read(st_r.pd_dir, st_r.pd_latch,
                          pd_lvl);
      end else if (reg_hit(i_axi_araddr, IDX_PORT_E_DATA)) begin
        r_val = port_read({{(REG_W-PE_W){1'b0}}, st_r.pe_dir},
                          {{(REG_W-PE_W){1'b0}}, st_r.pe_latch},
                          {{(REG_W-PE_W){1'b0}}, pe_lvl});
      end else if (reg_hit(i_axi_araddr, IDX_PORT_F_DATA)) begin
        r_val = port_read(st_r.pf_dir, st_r.pf_latch,
                          pf_lvl);
      end else if (reg_hit(i_axi_araddr, IDX_PORT_D_DIR)) begin
        r_val = st_r.pd_dir;
      end else if (reg_hit(i_axi_araddr, IDX_PORT_D_PUE)) begin
        r_val = st_r.pd_pue;
      end else if (reg_hit(i_axi_araddr, IDX_PORT_E_DIR)) begin
        r_val = {{(REG_W-PE_W){1'b0}}, st_r.pe_dir};
      end else if (reg_hit(i_axi_araddr, IDX_PORT_F_DIR)) begin
        r_val = st_r.pf_dir;
      end else begin
        r_ok = 1'b0;
      end
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = r_val;
      st_nxt.rresp  = r_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Reset clears control, leaves data latches alone
    if (i_reset) begin
      st_nxt          = '0;
      st_nxt.pd_latch = st_r.pd_latch;
      st_nxt.pe_latch = st_r.pe_latch;
      st_nxt.pf_latch = st_r.pf_latch;
      st_nxt.pd_dir   = PD_DIR_RST;
      st_nxt.pd_pue   = PD_PUE_RST;
      st_nxt.pe_dir   = PE_DIR_RST;
      st_nxt.pf_dir   = PF_DIR_RST;
      st_nxt.bresp    = RESP_OKAY;
      st_nxt.rresp    = RESP_OKAY;
    end
  end

  always_ff @(posedge i_mclk) begin
    st_r <= st_nxt;
  end

  // ***********************************************************
  // Bus outputs
  // ***********************************************************
  assign o_axi_awready = !st_r.aw_have && !st_r.bvalid;
  assign o_axi_wready  = !st_r.w_have && !st_r.bvalid;
  assign o_axi_bvalid  = st_r.bvalid;
  assign o_axi_bresp   = st_r.bresp;
  assign o_axi_arready = !st_r.rvalid;
  assign o_axi_rvalid  = st_r.rvalid;
  assign o_axi_rdata   = {{(DATA_W-REG_W){1'b0}}, st_r.rdata};
  assign o_axi_rresp   = st_r.rresp;

  // ***********************************************************
  // Port D pads
  // ***********************************************************
  logic [PD_W-1:0] pd_drive;
  logic [PD_W-1:0] pd_val;

  always_comb begin
    pd_drive = st_r.pd_dir;
    pd_val   = st_r.pd_latch;
    for (int i = 0; i < SPI_W; i++) begin
      if (i_spi_claim[i]) begin
        pd_drive[i] = i_spi_drive[i];
        pd_val[i]   = i_spi_out[i];
      end
    end
  end

  assign o_pd_out    = pd_val;
  assign o_pd_oe_n   = ~pd_drive;
  assign o_pd_pullup = st_r.pd_pue & ~st_r.pd_dir;
  assign o_spi_in    = pd_lvl[SPI_W-1:0];

  // ***********************************************************
  // Port E pads
  // ***********************************************************
  logic [PE_W-1:0] pe_drive;
  logic [PE_W-1:0] pe_val;

  always_comb begin
    pe_drive = st_r.pe_dir;
    pe_val   = st_r.pe_latch;
    if (i_serial_if_enable) begin
      pe_drive[PE_TX_BIT] = 1'b1;
      pe_val[PE_TX_BIT]   = i_serial_txd;
      pe_drive[PE_RX_BIT] = 1'b0;
      pe_val[PE_RX_BIT]   = 1'b0;
    end
  end

  assign o_pe_out     = pe_val;
  assign o_pe_oe_n    = ~pe_drive;
  assign o_serial_rxd = pe_lvl[PE_RX_BIT];

  // ***********************************************************
  // Port F pads
  // ***********************************************************
  logic [PF_W-1:0] pf_drive;
  logic [PF_W-1:0] pf_val;

  always_comb begin
    pf_drive = st_r.pf_dir;
    pf_val   = st_r.pf_latch;
    for (int i = 0; i < TIM_W; i++) begin
      if (i_timer_claim[i]) begin
        pf_drive[TIM_LSB+i] = i_timer_drive[i];
        pf_val[TIM_LSB+i]   = i_timer_out[i];
      end
    end
  end

  assign o_pf_out   = pf_val;
  assign o_pf_oe_n  = ~pf_drive;
  assign o_timer_in = pf_lvl[TIM_LSB +: TIM_W];

endmodule : gpio_ports_d_e_f

`default_nettype wire

//--- tb/gpio_ports_sva.sv
// Assertion checker for the port D, E and F pin logic
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_sva
  import gpio_def_pkg::*;
(
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_reset,
  // Register bus
  input wire logic        i_axi_awvalid,
  input wire logic        o_axi_awready,
  input wire logic [15:0] i_axi_awaddr,
  input wire logic        i_axi_wvalid,
  input wire logic        o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0]  i_axi_wstrb,
  input wire logic        o_axi_bvalid,
  input wire logic        i_axi_arvalid,
  input wire logic        o_axi_arready,
  input wire logic [15:0] i_axi_araddr,
  input wire logic [31:0] o_axi_rdata,
  // Pads
  input wire logic [7:0]  o_pd_out,
  input wire logic [7:0]  o_pd_oe_n,
  input wire logic [7:0]  o_pd_pullup,
  input wire logic [5:0]  o_pe_out,
  input wire logic [5:0]  o_pe_oe_n,
  input wire logic [7:0]  o_pf_out,
  input wire logic [7:0]  o_pf_oe_n,
  // Peripherals
  input wire logic [3:0]  i_spi_claim,
  input wire logic [3:0]  i_spi_drive,
  input wire logic [3:0]  i_spi_out,
  input wire logic        i_serial_if_enable,
  input wire logic        i_serial_txd,
  input wire logic [3:0]  i_timer_claim,
  input wire logic [3:0]  i_timer_drive,
  input wire logic [3:0]  i_timer_out
);
  logic [15:0] aw_r, ra_r;
  logic [7:0]  wd_r, m_r, v_r;
  logic        ws_r, rd_r;
  // Last write target and pad state at each read accept
  always_ff @(posedge i_mclk) begin
    if (i_axi_awvalid && o_axi_awready) aw_r <= i_axi_awaddr;
    if (i_axi_wvalid && o_axi_wready) wd_r <= i_axi_wdata[7:0];
    if (i_axi_wvalid && o_axi_wready) ws_r <= i_axi_wstrb[0];
    rd_r <= i_axi_arvalid && o_axi_arready && !i_reset;
    ra_r <= i_axi_araddr;
    m_r  <= ~o_pd_oe_n;
    v_r  <= o_pd_out;
  end
  a_reset_inputs: assert property (@(posedge i_mclk) disable iff (i_reset)
    $past(i_reset) |-> o_pd_oe_n[7:4] == 4'hf && o_pd_pullup == 8'h00
      && o_pe_oe_n[5:2] == 4'hf && o_pf_oe_n[3:0] == 4'hf) else $error("pins not input after reset");
  a_pd_dir_write: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_axi_bvalid && ws_r && aw_r == 16'h0040 |-> o_pd_oe_n[7:4] == ~wd_r[7:4]) else $error("D drive wrong");
  a_pf_dir_write: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_axi_bvalid && ws_r && aw_r == 16'h004c |-> o_pf_oe_n[3:0] == ~wd_r[3:0]) else $error("F drive wrong");
  a_pe_dir_gpio: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_axi_bvalid && ws_r && aw_r == 16'h0048 && !i_serial_if_enable |-> o_pe_oe_n == ~wd_r[5:0])
    else $error("E drive wrong");
  a_pull_enable: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_axi_bvalid && ws_r && aw_r == 16'h0044 |-> o_pd_pullup[7:4] == (wd_r[7:4] & o_pd_oe_n[7:4]))
    else $error("pullup enable wrong");
  a_pull_off_out: assert property (@(posedge i_mclk) disable iff (i_reset)
    (o_pd_pullup[7:4] & ~o_pd_oe_n[7:4]) == 4'h0) else $error("pullup on driving pin");
  a_spi_owns_pin: assert property (@(posedge i_mclk) disable iff (i_reset)
    ((o_pd_out[3:0] ^ i_spi_out) & i_spi_claim) == 4'h0
      && ((o_pd_oe_n[3:0] ^ ~i_spi_drive) & i_spi_claim) == 4'h0) else $error("SPI pin wrong");
  a_timer_owns: assert property (@(posedge i_mclk) disable iff (i_reset)
    ((o_pf_out[7:4] ^ i_timer_out) & i_timer_claim) == 4'h0
      && ((o_pf_oe_n[7:4] ^ ~i_timer_drive) & i_timer_claim) == 4'h0) else $error("timer pin wrong");
  a_serial_owns: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_serial_if_enable |-> o_pe_oe_n[1:0] == 2'b10 && o_pe_out[0] == i_serial_txd)
    else $error("serial pins wrong");
  a_pd_read_latch: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_r && ra_r == 16'h000c |-> ((o_axi_rdata[7:4] ^ v_r[7:4]) & m_r[7:4]) == 4'h0
      && o_axi_rdata[31:8] == 24'h0) else $error("D read not latch");
  a_pe_read_width: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_r && ra_r == 16'h0020 |-> o_axi_rdata[31:6] == 26'h0) else $error("E read too wide");
endmodule : gpio_ports_sva
bind gpio_ports_d_e_f gpio_ports_sva chk (.*);
`default_nettype wire

//--- tb/pad_model.sv
// Pad model: design drive, pullup and a far-side source per pin
`timescale 1ns/1ps
`default_nettype none
module pad_model #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         i_mclk,
  // Design side
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe_n,
  input  wire logic [W-1:0] i_pull,
  // Far-side source
  input  wire logic [W-1:0] i_ext,
  input  wire logic [W-1:0] i_ext_en,
  output logic      [W-1:0] o_pin
);
  logic [W-1:0] float_r = '0;
  // Undriven pad keeps changing so no stale level reads as valid
  always_ff @(posedge i_mclk) float_r <= ~float_r;
  assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext_en & i_ext)
               | (i_oe_n & ~i_ext_en & (i_pull | float_r));
endmodule : pad_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the port D, E and F pin logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpio_def_pkg::*;
  logic i_mclk, i_reset, i_axi_awvalid, i_axi_wvalid, i_axi_bready;
  logic i_axi_arvalid, i_axi_rready, o_axi_awready, o_axi_wready;
  logic o_axi_bvalid, o_axi_arready, o_axi_rvalid, o_serial_rxd;
  logic i_serial_if_enable, i_serial_txd;
  logic [15:0] i_axi_awaddr, i_axi_araddr;
  logic [31:0] i_axi_wdata, o_axi_rdata, rv;
  logic [2:0]  i_axi_awprot, i_axi_arprot;
  logic [1:0]  o_axi_bresp, o_axi_rresp;
  logic [3:0]  i_axi_wstrb, i_spi_claim, i_spi_drive, i_spi_out, o_spi_in;
  logic [3:0]  i_timer_claim, i_timer_drive, i_timer_out, o_timer_in;
  logic [7:0]  i_pd_in, o_pd_out, o_pd_oe_n, o_pd_pullup;
  logic [7:0]  i_pf_in, o_pf_out, o_pf_oe_n;
  logic [5:0]  i_pe_in, o_pe_out, o_pe_oe_n;
  logic [7:0]  ext_v [3], ext_en [3];
  logic [15:0] dat_a [3] = '{16'h000c, 16'h0020, 16'h1100};
  logic [15:0] dir_a [3] = '{16'h0040, 16'h0048, 16'h004c};
  logic [7:0]  pv [3] = '{8'h00, 8'hf0, 8'h00};
  logic [15:0] lfsr_r = 16'h10e1;
  int msk [3] = '{32'hff, 32'h3f, 32'hff};
  int lat [3], dir [3], pue, error_cnt, tests_run, cyc;

  gpio_ports_d_e_f uut (.*);
  pad_model #(.W(8)) pad_d (.i_mclk, .i_out(o_pd_out), .i_oe_n(o_pd_oe_n),
    .i_pull(o_pd_pullup), .i_ext(ext_v[0]), .i_ext_en(ext_en[0]), .o_pin(i_pd_in));
  pad_model #(.W(6)) pad_e (.i_mclk, .i_out(o_pe_out), .i_oe_n(o_pe_oe_n),
    .i_pull(6'h00), .i_ext(ext_v[1][5:0]), .i_ext_en(ext_en[1][5:0]), .o_pin(i_pe_in));
  pad_model #(.W(8)) pad_f (.i_mclk, .i_out(o_pf_out), .i_oe_n(o_pf_oe_n),
    .i_pull(8'h00), .i_ext(ext_v[2]), .i_ext_en(ext_en[2]), .o_pin(i_pf_in));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // Seed 4321, eight shifts per draw
  function automatic logic [7:0] rnd();
    repeat (8) lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r[7:0];
  endfunction : rnd

  // Read value: latch where output, pin level where input
  function automatic int expd(int p);
    int pin;
    pin = (ext_en[p] & ext_v[p]) | (~ext_en[p] & (p == 0 ? pue : 0));
    return ((lat[p] & dir[p]) | (pin & ~dir[p])) & msk[p];
  endfunction : expd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ***********************************************************
  // Register bus master
  // ***********************************************************
  task automatic axw(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge i_mclk);
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready} <= 3'h7;
    i_axi_awaddr <= a;
    i_axi_wdata <= {24'h0, d};
    while (!(ad && wd)) begin
      @(posedge i_mclk);
      if (i_axi_awvalid && o_axi_awready) begin ad = 1'b1; i_axi_awvalid <= 1'b0; end
      if (i_axi_wvalid && o_axi_wready) begin wd = 1'b1; i_axi_wvalid <= 1'b0; end
    end
    while (!o_axi_bvalid) @(posedge i_mclk);
    i_axi_bready <= 1'b0;
    chk({30'h0, o_axi_bresp}, {30'h0, er});
  endtask : axw

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_mclk);
    {i_axi_arvalid, i_axi_rready} <= 2'h3;
    i_axi_araddr <= a;
    do @(posedge i_mclk); while (!o_axi_arready);
    i_axi_arvalid <= 1'b0;
    do @(posedge i_mclk); while (!o_axi_rvalid);
    i_axi_rready <= 1'b0;
    chk(o_axi_rdata, e);
    chk({30'h0, o_axi_rresp}, {30'h0, er});
  endtask : rd

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  initial begin
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready} = '0;
    {i_axi_awaddr, i_axi_araddr, i_axi_awprot, i_axi_arprot, i_axi_wdata} = '0;
    {i_spi_claim, i_spi_drive, i_spi_out, i_serial_if_enable, i_serial_txd} = '0;
    {i_timer_claim, i_timer_drive, i_timer_out} = '0;
    i_axi_wstrb = 4'hf;
    foreach (ext_v[p]) begin ext_v[p] = 8'h00; ext_en[p] = 8'hff; end
    i_reset = 1'b1;
    repeat (8) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (int p = 0; p < 3; p++) rd(dir_a[p], 32'h0, RESP_OKAY);
    rd(16'h0044, 32'h0, RESP_OKAY);
    $display("test reset values done");
    for (int p = 0; p < 3; p++) begin
      ext_v[p] <= rnd();
      lat[p] = rnd();
      axw(dat_a[p], lat[p][7:0], RESP_OKAY);
      repeat (8) @(posedge i_mclk);
      rd(dat_a[p], expd(p), RESP_OKAY);
      dir[p] = rnd() & msk[p];
      axw(dir_a[p], dir[p][7:0], RESP_OKAY);
      rd(dir_a[p], dir[p], RESP_OKAY);
      rd(dat_a[p], expd(p), RESP_OKAY);
    end
    $display("test data paths done");
    @(posedge i_mclk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      dir[p] = msk[p];
      axw(dir_a[p], msk[p][7:0], RESP_OKAY);
      rd(dat_a[p], expd(p), RESP_OKAY);
    end
    $display("test latch across reset done");
    ext_en[0] <= 8'h00;
    pue = 32'hff;
    axw(16'h0044, 8'hff, RESP_OKAY);
    rd(16'h0044, 32'hff, RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      dir[0] = pv[k];
      axw(dir_a[0], pv[k], RESP_OKAY);
      repeat (8) @(posedge i_mclk);
      rd(dat_a[0], expd(0), RESP_OKAY);
    end
    ext_en[0] <= 8'hff;
    $display("test pullups done");
    axw(16'h0004, 8'h5a, RESP_SLVERR);
    axw(16'h000d, 8'h5a, RESP_SLVERR);
    rd(16'h0004, 32'h0, RESP_SLVERR);
    rd(dat_a[0], expd(0), RESP_OKAY);
    $display("test unmapped done");
    repeat (40) begin
      @(posedge i_mclk);
      rv = {rnd(), rnd(), rnd(), rnd()};
      {i_spi_claim, i_spi_drive, i_spi_out, i_timer_claim} <= rv[15:0];
      {i_timer_drive, i_timer_out, i_serial_if_enable, i_serial_txd} <= rv[25:16];
    end
    @(posedge i_mclk);
    {i_spi_claim, i_timer_claim, i_serial_if_enable} <= 9'h001;
    dir[1] = 32'h3f;
    axw(dir_a[1], 8'h3f, RESP_OKAY);
    rd(dat_a[1], expd(1), RESP_OKAY);
    chk({28'h0, o_spi_in}, {28'h0, ext_v[0][3:0]});
    chk({31'h0, o_serial_rxd}, {31'h0, ext_v[1][1]});
    chk({28'h0, o_timer_in}, (((lat[2] & dir[2]) | (ext_v[2] & ~dir[2])) >> 4) & 32'hf);
    $display("test shared pins done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
